/* File: design/tk_pkg.sv */
package tk_pkg;
	localparam int NUM_KEYS     = 24;
	localparam int SETUP_BYTES  = 100;
	localparam int DIAG_BYTES   = 5;
	localparam int STATUS_BYTES = 2;

	localparam logic [7:0] CMD_DUMP  = 8'h0d;
	localparam logic [7:0] CMD_CRC   = 8'h0e;
	localparam logic [7:0] CMD_ECHO  = 8'h0f;
	localparam logic [1:0] GRP_DIAG  = 2'h1;
	localparam logic [1:0] GRP_STAT  = 2'h2;
	localparam logic [1:0] GRP_CAL   = 2'h3;
	localparam logic [7:0] IDLE_BYTE = 8'h00;

	// Layout of the setup area as this block reads it after reset.
	localparam logic [6:0] OFS_NEG_THRESHOLD_SETTING   = 7'h00;
	localparam logic [6:0] OFS_DOWN_DRIFT_RATE = 7'h18;
	localparam logic [6:0] OFS_LSL    = 7'h30;
	localparam logic [6:0] LOAD_LAST  = 7'h31;
	localparam logic [6:0] SETUP_LAST = 7'h63;
	localparam logic [7:0] DEF_NEG_THRESHOLD_SETTING   = 8'h06;
	localparam logic [7:0] DEF_DOWN_DRIFT_RATE = 8'h0a;
	localparam logic [7:0] DEF_LSL_LO = 8'h64;
	localparam logic [7:0] DEF_LSL_HI = 8'h00;
	localparam logic [7:0] CRC_POLY   = 8'h07;

	localparam int THR_ADD     = 4;
	localparam int POS_THR     = 6;
	localparam int HYST_SHIFT  = 3;
	localparam int HYST_SCALE  = 8;

	localparam int CLK_PERIOD_NS = 4;
	localparam int CAL_WINDOW_MS = 100;
	localparam int TICK_MS       = 50;
	localparam int UP_DRIFT_MS   = 400;
	localparam int DOWN_UNIT_MS  = 250;
	localparam int NS_PER_MS     = 1000000;
	localparam int CAL_WINDOW_CYC = CAL_WINDOW_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int DRIFT_TICK_CYC = TICK_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int UP_TICKS       = UP_DRIFT_MS / TICK_MS;
	localparam int DOWN_TICKS     = DOWN_UNIT_MS / TICK_MS;
	localparam logic [11:0] TICK_SAT = 12'hfff;

	typedef enum logic [4:0] {
		ST_LOAD  = 5'h01,
		ST_IDLE  = 5'h02,
		ST_REPLY = 5'h04,
		ST_DUMP  = 5'h08,
		ST_SUM   = 5'h10
	} tk_state_t;

	function automatic logic [7:0] tkCrc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	function automatic logic [7:0] tkSetupDefault(input logic [6:0] addr);
		logic [7:0] v;
		v = 8'h00;
		if (addr < OFS_DOWN_DRIFT_RATE) begin
			v = DEF_NEG_THRESHOLD_SETTING;
		end else if (addr < OFS_LSL) begin
			v = DEF_DOWN_DRIFT_RATE;
		end else if (addr == OFS_LSL) begin
			v = DEF_LSL_LO;
		end else if (addr == LOAD_LAST) begin
			v = DEF_LSL_HI;
		end
		return v;
	endfunction
endpackage

/* File: design/tk_setup_mem.sv */
`timescale 1ns/1ns
module tk_setup_mem import tk_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rstN,
	input  wire logic       wrEn,
	input  wire logic [6:0] wrAddr,
	input  wire logic [7:0] wrData,
	input  wire logic [6:0] rdAddr,
	output logic      [7:0] rdData
);
	logic [7:0] mem_q [SETUP_BYTES];

	// Power-up contents stand in for factory programming. Reset leaves the array
	// alone, so a loaded setups block survives and takes effect at the next reset.
	initial begin
		for (int i = 0; i < SETUP_BYTES; i++) begin
			mem_q[i] = tkSetupDefault(7'(i));
		end
	end

	always_ff @(posedge clk) begin
		if (wrEn && wrAddr <= SETUP_LAST) begin
			mem_q[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rdData <= 8'h00;
		end else begin
			rdData <= (rdAddr <= SETUP_LAST) ? mem_q[rdAddr] : 8'h00;
		end
	end
endmodule

/* File: design/tk_spi_link.sv */
`timescale 1ns/1ns
module tk_spi_link (
	input  wire logic       spiClk,
	input  wire logic       spiCsN,
	input  wire logic       spiMosi,
	input  wire logic       linkRstN,
	input  wire logic [7:0] txByte,
	output logic            spiMisoOut,
	output logic            spiMisoOe,
	output logic            rxToggle,
	output logic      [7:0] rxByte
);
	logic [2:0] bitCnt_q;
	logic [6:0] rxSh_q;
	logic [7:0] txSh_q;

	always_ff @(posedge spiClk or posedge spiCsN) begin
		if (spiCsN) begin
			bitCnt_q <= 3'h0;
			rxSh_q   <= 7'h00;
		end else begin
			bitCnt_q <= bitCnt_q + 3'h1;
			rxSh_q   <= {rxSh_q[5:0], spiMosi};
		end
	end

	// The byte is held until the next one completes, so the core may read it
	// once the toggle has crossed.
	always_ff @(posedge spiClk or negedge linkRstN) begin
		if (!linkRstN) begin
			rxByte   <= 8'h00;
			rxToggle <= 1'b0;
		end else if (bitCnt_q == 3'h7) begin
			rxByte   <= {rxSh_q, spiMosi};
			rxToggle <= ~rxToggle;
		end
	end

	// The core keeps txByte still during a byte, so it is taken here unsynchronised.
	always_ff @(negedge spiClk or posedge spiCsN) begin
		if (spiCsN) begin
			txSh_q <= 8'h00;
		end else if (bitCnt_q == 3'h1) begin
			txSh_q <= {txByte[6:0], 1'b0};
		end else begin
			txSh_q <= {txSh_q[6:0], 1'b0};
		end
	end

	assign spiMisoOut = (bitCnt_q == 3'h0) ? txByte[7] : txSh_q[7];
	assign spiMisoOe  = ~spiCsN;
endmodule

/* File: design/tk_touch_keys.sv */
`timescale 1ns/1ns
// How it works
// - Setup dump halts scanning, sends 100 setup bytes plus checksum, then resumes.
// - Checksum command returns one CRC-8 over the stored setup array only.
// - Echo command returns complement of previous command byte and clears comms error.
// - Diagnostic command returns signal, reference (low byte first) and integrator count.
// - Status command returns key status byte then checksum over command and data.
// - Forced key calibration needs the same command twice within 100 ms.
// - Scheduled calibration runs in the key's own slot; reply is complemented command.
// - Setups live in nonvolatile memory and take effect only after reset.
// - Touch when signal falls below reference by stored threshold plus four.
// - Thresholds follow the reference whenever it moves.
// - Negative hysteresis is fixed at one eighth of the negative threshold.
// - Positive threshold is six counts with fixed one-eighth hysteresis.
// - Reference drifts toward signal, slew limited, only while not in detect.
// - Upward drift moves one count every 0.4 seconds.
// - Downward drift rate per key comes from setup; 10 means 2.5 s per count.
// - Default threshold setting gives ten counts below reference.
// - Second identical command missing for 100 ms means timeout and no reply.
// - Unrecognised command sets the comms error flag.
module tk_touch_keys import tk_pkg::*; #(
	parameter int WINDOW_CYC = CAL_WINDOW_CYC,
	parameter int TICK_CYC   = DRIFT_TICK_CYC
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         spiClk,
	input  wire logic         spiCsN,
	input  wire logic         spiMosi,
	output logic              spiMisoOut,
	output logic              spiMisoOe,
	input  wire logic         sampleValid,
	input  wire logic [4:0]   sampleKey,
	input  wire logic [15:0]  sampleSignal,
	input  wire logic [23:0]  keyEnabled,
	input  wire logic [23:0]  keyCalibrating,
	input  wire logic [23:0]  keyCalFail,
	input  wire logic [191:0] keyNormCount,
	input  wire logic         setupWrEn,
	input  wire logic [6:0]   setupWrAddr,
	input  wire logic [7:0]   setupWrData,
	output logic              scanHalt,
	output logic [23:0]       keyDetect,
	output logic [23:0]       keyPosOver,
	output logic              calStart,
	output logic [4:0]        calKey,
	output logic              commsErr
);
	logic [1:0]  rstSync_q;
	logic        rstN;
	logic [2:0]  rxSync_q;
	logic        rxToggle;
	logic [7:0]  rxByte;
	logic        rxNew;
	logic [7:0]  memRd;
	tk_state_t   state_q;
	logic [6:0]  memAddr_q, memPrev_q;
	logic        rdVal_q;
	logic [1:0]  fetch_q;
	logic [6:0]  dumpIdx_q;
	logic [7:0]  crc_q, txByte_q, lastCmd_q, armCmd_q;
	logic [7:0]  reply_q [4];
	logic [2:0]  left_q, idx_q;
	logic        armed_q, calSet_q, commsErr_q, scanHalt_q;
	logic [4:0]  calSetKey_q;
	logic [31:0] winCnt_q, tickCnt_q;
	logic        tick;
	logic [15:0] sig_q [NUM_KEYS];
	logic [15:0] ref_q [NUM_KEYS];
	logic [11:0] age_q [NUM_KEYS];
	logic [7:0]  thrSet_q [NUM_KEYS];
	logic [7:0]  driftSet_q [NUM_KEYS];
	logic [15:0] lsl_q;
	logic [23:0] refValid_q, detect_q, posOver_q, calPend_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstN = rstSync_q[1];

	tk_spi_link uLink (
		.spiClk     (spiClk),
		.spiCsN     (spiCsN),
		.spiMosi    (spiMosi),
		.linkRstN   (rst_n),
		.txByte     (txByte_q),
		.spiMisoOut (spiMisoOut),
		.spiMisoOe  (spiMisoOe),
		.rxToggle   (rxToggle),
		.rxByte     (rxByte)
	);

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			rxSync_q <= 3'h0;
		end else begin
			rxSync_q <= {rxSync_q[1:0], rxToggle};
		end
	end
	assign rxNew = rxSync_q[2] ^ rxSync_q[1];

	tk_setup_mem uMem (
		.clk    (ref_clk),
		.rstN   (rstN),
		.wrEn   (setupWrEn),
		.wrAddr (setupWrAddr),
		.wrData (setupWrData),
		.rdAddr (memAddr_q),
		.rdData (memRd)
	);

	// Per-key settings are copied out once after reset; later writes wait for the next one.
	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			lsl_q <= 16'h0000;
			for (int i = 0; i < NUM_KEYS; i++) begin
				thrSet_q[i]   <= 8'h00;
				driftSet_q[i] <= 8'h00;
			end
		end else if (state_q == ST_LOAD && rdVal_q) begin
			if (memPrev_q < OFS_DOWN_DRIFT_RATE) begin
				thrSet_q[memPrev_q[4:0]] <= memRd;
			end else if (memPrev_q < OFS_LSL) begin
				driftSet_q[5'(memPrev_q - OFS_DOWN_DRIFT_RATE)] <= memRd;
			end else if (memPrev_q == OFS_LSL) begin
				lsl_q[7:0] <= memRd;
			end else begin
				lsl_q[15:8] <= memRd;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			tickCnt_q <= 32'h0;
		end else begin
			tickCnt_q <= (tickCnt_q >= 32'(TICK_CYC - 1)) ? 32'h0 : tickCnt_q + 32'h1;
		end
	end
	assign tick = (tickCnt_q == 32'h0);

	logic        sampOk;
	logic [4:0]  kIdx;
	int          thrEff, negDev, downTicks, age;
	logic        detNext, posNext;

	always_comb begin
		sampOk    = sampleValid && (sampleKey < 5'(NUM_KEYS)) && !scanHalt_q;
		kIdx      = sampOk ? sampleKey : 5'h0;
		thrEff    = int'(thrSet_q[kIdx]) + THR_ADD;
		negDev    = int'(ref_q[kIdx]) - int'(sampleSignal);
		downTicks = int'(driftSet_q[kIdx]) * DOWN_TICKS;
		age       = int'(age_q[kIdx]);
		// Hysteresis compared in eighths keeps the 12.5 % exact.
		detNext = detect_q[kIdx] ?
			(negDev * HYST_SCALE >= thrEff * HYST_SCALE - thrEff) : (negDev >= thrEff);
		posNext = posOver_q[kIdx] ?
			(-negDev * HYST_SCALE >= POS_THR * HYST_SCALE - POS_THR) :
			(-negDev >= POS_THR);
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			refValid_q <= 24'h0;
			detect_q   <= 24'h0;
			posOver_q  <= 24'h0;
			calPend_q  <= 24'h0;
			calStart   <= 1'b0;
			calKey     <= 5'h0;
			for (int i = 0; i < NUM_KEYS; i++) begin
				sig_q[i] <= 16'h0;
				ref_q[i] <= 16'h0;
				age_q[i] <= 12'h0;
			end
		end else begin
			calStart <= 1'b0;
			if (tick) begin
				for (int i = 0; i < NUM_KEYS; i++) begin
					if (age_q[i] != TICK_SAT) begin
						age_q[i] <= age_q[i] + 12'h1;
					end
				end
			end
			if (sampOk) begin
				sig_q[kIdx] <= sampleSignal;
				if (calPend_q[kIdx] || !refValid_q[kIdx]) begin
					ref_q[kIdx]      <= sampleSignal;
					refValid_q[kIdx] <= 1'b1;
					detect_q[kIdx]   <= 1'b0;
					posOver_q[kIdx]  <= 1'b0;
					age_q[kIdx]      <= 12'h0;
					calPend_q[kIdx]  <= 1'b0;
					calStart         <= calPend_q[kIdx];
					calKey           <= kIdx;
				end else begin
					detect_q[kIdx]  <= detNext;
					posOver_q[kIdx] <= posNext;
					if (!detect_q[kIdx]) begin
						if (negDev < 0 && age >= UP_TICKS) begin
							ref_q[kIdx] <= ref_q[kIdx] + 16'h1;
							age_q[kIdx] <= 12'h0;
						end else if (negDev > 0 && age >= downTicks) begin
							ref_q[kIdx] <= ref_q[kIdx] - 16'h1;
							age_q[kIdx] <= 12'h0;
						end else if (negDev == 0) begin
							age_q[kIdx] <= 12'h0;
						end
					end
				end
			end
			// A new schedule beats a clear in the same cycle.
			if (calSet_q) begin
				calPend_q[calSetKey_q] <= 1'b1;
			end
		end
	end

	logic [7:0] cmdCrc, statByte;
	logic [4:0] cmdKey;
	logic       keyOk;

	always_comb begin
		keyOk    = (rxByte[5:0] < 6'(NUM_KEYS));
		cmdKey   = keyOk ? rxByte[4:0] : 5'h0;
		cmdCrc   = tkCrc8(8'h00, rxByte);
		statByte = {3'h0, keyEnabled[cmdKey], detect_q[cmdKey],
			(ref_q[cmdKey] < lsl_q), keyCalibrating[cmdKey] | calPend_q[cmdKey],
			keyCalFail[cmdKey]};
	end

	always_ff @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			state_q     <= ST_LOAD;
			memAddr_q   <= 7'h0;
			memPrev_q   <= 7'h0;
			rdVal_q     <= 1'b0;
			fetch_q     <= 2'h0;
			dumpIdx_q   <= 7'h0;
			crc_q       <= 8'h0;
			txByte_q    <= IDLE_BYTE;
			lastCmd_q   <= 8'h0;
			armCmd_q    <= 8'h0;
			armed_q     <= 1'b0;
			winCnt_q    <= 32'h0;
			left_q      <= 3'h0;
			idx_q       <= 3'h0;
			calSet_q    <= 1'b0;
			calSetKey_q <= 5'h0;
			commsErr_q  <= 1'b0;
			scanHalt_q  <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				reply_q[i] <= 8'h0;
			end
		end else begin
			memPrev_q <= memAddr_q;
			rdVal_q   <= (state_q == ST_LOAD) || (state_q == ST_SUM);
			fetch_q   <= {fetch_q[0], 1'b0};
			calSet_q  <= 1'b0;
			if (armed_q) begin
				if (winCnt_q == 32'h0) begin
					armed_q <= 1'b0;
				end else begin
					winCnt_q <= winCnt_q - 32'h1;
				end
			end
			case (state_q)
				ST_LOAD: begin
					if (memAddr_q != LOAD_LAST) begin
						memAddr_q <= memAddr_q + 7'h1;
					end
					if (rdVal_q && memPrev_q == LOAD_LAST) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (rxNew) begin
						lastCmd_q <= rxByte;
						if (!(rxByte[7:6] == GRP_CAL && keyOk)) begin
							armed_q <= 1'b0;
						end
						if (rxByte == CMD_DUMP) begin
							state_q    <= ST_DUMP;
							scanHalt_q <= 1'b1;
							memAddr_q  <= 7'h0;
							dumpIdx_q  <= 7'h0;
							fetch_q    <= 2'h1;
							crc_q      <= cmdCrc;
						end else if (rxByte == CMD_CRC) begin
							state_q   <= ST_SUM;
							memAddr_q <= 7'h0;
							crc_q     <= 8'h0;
						end else if (rxByte == CMD_ECHO) begin
							txByte_q   <= ~lastCmd_q;
							commsErr_q <= 1'b0;
							left_q     <= 3'h1;
							state_q    <= ST_REPLY;
						end else if (rxByte[7:6] == GRP_DIAG && keyOk) begin
							txByte_q   <= sig_q[cmdKey][7:0];
							reply_q[0] <= sig_q[cmdKey][15:8];
							reply_q[1] <= ref_q[cmdKey][7:0];
							reply_q[2] <= ref_q[cmdKey][15:8];
							reply_q[3] <= keyNormCount[cmdKey * 8 +: 8];
							left_q     <= 3'(DIAG_BYTES);
							idx_q      <= 3'h0;
							state_q    <= ST_REPLY;
						end else if (rxByte[7:6] == GRP_STAT && keyOk) begin
							txByte_q   <= statByte;
							reply_q[0] <= tkCrc8(cmdCrc, statByte);
							left_q     <= 3'(STATUS_BYTES);
							idx_q      <= 3'h0;
							state_q    <= ST_REPLY;
						end else if (rxByte[7:6] == GRP_CAL && keyOk) begin
							if (armed_q && armCmd_q == rxByte) begin
								armed_q     <= 1'b0;
								calSet_q    <= 1'b1;
								calSetKey_q <= cmdKey;
								txByte_q    <= ~rxByte;
								left_q      <= 3'h1;
								state_q     <= ST_REPLY;
							end else begin
								armed_q  <= 1'b1;
								armCmd_q <= rxByte;
								winCnt_q <= 32'(WINDOW_CYC - 1);
							end
						end else begin
							commsErr_q <= 1'b1;
						end
					end
				end
				ST_SUM: begin
					if (memAddr_q != SETUP_LAST) begin
						memAddr_q <= memAddr_q + 7'h1;
					end
					if (rdVal_q) begin
						crc_q <= tkCrc8(crc_q, memRd);
						if (memPrev_q == SETUP_LAST) begin
							txByte_q <= tkCrc8(crc_q, memRd);
							left_q   <= 3'h1;
							state_q  <= ST_REPLY;
						end
					end
				end
				ST_DUMP: begin
					if (fetch_q[1]) begin
						txByte_q <= memRd;
						crc_q    <= tkCrc8(crc_q, memRd);
					end
					if (rxNew) begin
						if (dumpIdx_q == SETUP_LAST) begin
							txByte_q <= crc_q;
							left_q   <= 3'h1;
							state_q  <= ST_REPLY;
						end else begin
							dumpIdx_q <= dumpIdx_q + 7'h1;
							memAddr_q <= dumpIdx_q + 7'h1;
							fetch_q   <= 2'h1;
						end
					end
				end
				ST_REPLY: begin
					if (rxNew) begin
						if (left_q == 3'h1) begin
							txByte_q   <= IDLE_BYTE;
							scanHalt_q <= 1'b0;
							state_q    <= ST_IDLE;
						end else begin
							txByte_q <= reply_q[idx_q[1:0]];
							idx_q    <= idx_q + 3'h1;
						end
						left_q <= left_q - 3'h1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign scanHalt   = scanHalt_q;
	assign keyDetect  = detect_q;
	assign keyPosOver = posOver_q;
	assign commsErr   = commsErr_q;
endmodule

/* File: sim/tk_touch_keys_chk.sv */
`timescale 1ns/1ns
module tk_touch_keys_chk (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        spiCsN,
	input wire logic        spiMisoOe,
	input wire logic        sampleValid,
	input wire logic [4:0]  sampleKey,
	input wire logic        scanHalt,
	input wire logic [23:0] keyDetect,
	input wire logic [23:0] keyPosOver,
	input wire logic        calStart,
	input wire logic [4:0]  calKey
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_oe;
		spiMisoOe == !spiCsN;
	endproperty
	a_oe: assert property (p_oe) else $error("miso enable wrong");
	// A detect change must come from one accepted sample, outside a dump.
	property p_det;
		$changed(keyDetect) |-> $past(sampleValid) && !$past(scanHalt)
			&& ((keyDetect ^ $past(keyDetect)) == (24'h1 << $past(sampleKey)));
	endproperty
	a_det: assert property (p_det) else $error("detect changed without sample");
	property p_pos;
		$changed(keyPosOver) |-> $past(sampleValid) && !$past(scanHalt)
			&& ((keyPosOver ^ $past(keyPosOver)) == (24'h1 << $past(sampleKey)));
	endproperty
	a_pos: assert property (p_pos) else $error("positive flag changed without sample");
	property p_mutex;
		(keyDetect & keyPosOver) == 24'h0;
	endproperty
	a_mutex: assert property (p_mutex) else $error("key both below and above");
	property p_halt;
		$rose(scanHalt) |=> scanHalt [*8];
	endproperty
	a_halt: assert property (p_halt) else $error("scan halt too short");
	property p_calPulse;
		calStart |=> !calStart;
	endproperty
	a_calPulse: assert property (p_calPulse) else $error("calibration pulse too long");
	property p_calKey;
		calStart |-> calKey < 5'd24;
	endproperty
	a_calKey: assert property (p_calKey) else $error("calibration key out of range");
	property p_calSlot;
		calStart |-> ($past(sampleValid) && $past(sampleKey) == calKey)
			|| ($past(sampleValid, 2) && $past(sampleKey, 2) == calKey);
	endproperty
	a_calSlot: assert property (p_calSlot) else $error("calibration outside key slot");

	c_cal: cover property (calStart);
	c_halt: cover property ($rose(scanHalt));
	c_det: cover property ($rose(|keyDetect));
endmodule

bind tk_touch_keys tk_touch_keys_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .spiCsN(spiCsN),
	.spiMisoOe(spiMisoOe), .sampleValid(sampleValid), .sampleKey(sampleKey),
	.scanHalt(scanHalt), .keyDetect(keyDetect), .keyPosOver(keyPosOver),
	.calStart(calStart), .calKey(calKey));

/* File: sim/tk_spi_host.sv */
`timescale 1ns/1ns
// Host side of the serial port; its clock only runs inside a frame.
module tk_spi_host (
	output logic           spiClk,
	output logic           spiCsN,
	output logic           spiMosi,
	input  wire logic      spiMisoOut,
	input  wire logic      spiMisoOe
);
	initial begin
		spiClk = 1'b0;
		spiCsN = 1'b1;
		spiMosi = 1'b1;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		spiCsN = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			spiMosi = tx[i];
			#7;
			// Taken before the edge, since the device moves its output on it.
			rx[i] = spiMisoOe ? spiMisoOut : 1'bx;
			spiClk = 1'b1;
			#8;
			spiClk = 1'b0;
		end
		spiCsN = 1'b1;
		// The line floats once deselected, so show the opposite level.
		spiMosi = ~spiMosi;
	endtask
endmodule

/* File: sim/test_touch_key_host_commands_thresholds.sv */
`timescale 1ns/1ns
module test_touch_key_host_commands_thresholds import tk_pkg::*;;
	localparam int WIN = 200;
	localparam int TICK = 20;
	logic         refClk;
	logic         rstN;
	logic         sampleValid;
	logic [4:0]   sampleKey;
	logic [15:0]  sampleSignal;
	logic [23:0]  keyEnabled, keyCalibrating, keyCalFail, keyDetect, keyPosOver;
	logic [191:0] keyNormCount;
	logic         setupWrEn;
	logic [6:0]   setupWrAddr;
	logic [7:0]   setupWrData, lfsr, rx;
	logic         spiClk, spiCsN, spiMosi, spiMisoOut, spiMisoOe;
	logic         scanHalt, calStart, commsErr;
	logic [4:0]   calKey, lastCal;
	logic [7:0]   got[$];
	int           bad_count, comparisons;
	int           calCount = 0;

	tk_touch_keys #(.WINDOW_CYC(WIN), .TICK_CYC(TICK)) DUT (
		.ref_clk(refClk), .rst_n(rstN), .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
		.spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe), .sampleValid(sampleValid),
		.sampleKey(sampleKey), .sampleSignal(sampleSignal), .keyEnabled(keyEnabled),
		.keyCalibrating(keyCalibrating), .keyCalFail(keyCalFail), .keyNormCount(keyNormCount),
		.setupWrEn(setupWrEn), .setupWrAddr(setupWrAddr), .setupWrData(setupWrData),
		.scanHalt(scanHalt), .keyDetect(keyDetect), .keyPosOver(keyPosOver),
		.calStart(calStart), .calKey(calKey), .commsErr(commsErr));
	tk_spi_host host (.spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
		.spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe));

	initial begin
		refClk = 1'b0;
		forever #2 refClk = ~refClk;
	end
	always @(posedge refClk) begin
		if (calStart === 1'b1) begin
			calCount++;
			lastCal = calKey;
		end
	end

	function automatic logic [7:0] nextRand(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
		end
		return r;
	endfunction
	function automatic logic [7:0] setupExp(input int a);
		return a < 24 ? 8'h06 : a < 48 ? 8'h0a : a == 48 ? 8'h64 : 8'h00;
	endfunction

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic sample(input logic [4:0] k, input logic [15:0] s);
		@(posedge refClk);
		sampleValid <= 1'b1;
		sampleKey <= k;
		sampleSignal <= s;
		@(posedge refClk);
		sampleValid <= 1'b0;
		@(posedge refClk);
	endtask
	// The gap leaves the core time to cross the byte and prepare its answer.
	task automatic xf(input logic [7:0] c);
		host.xfer(c, rx);
		#300;
	endtask
	task automatic query(input logic [7:0] c, input int n);
		got.delete();
		xf(c);
		if (c == CMD_CRC) #1500;
		repeat (n) begin
			xf(8'h00);
			got.push_back(rx);
		end
	endtask
	task automatic refIs(input logic [4:0] k, input logic [15:0] e);
		query({3'b010, k}, 5);
		check({got[3], got[2]}, e);
	endtask

	initial begin
		#200000;
		bad_count++;
		results();
	end

	initial begin
		logic [15:0] b;
		logic [7:0]  st, s1, s2;
		logic [4:0]  k;
		bad_count = 0;
		comparisons = 0;
		lfsr = 8'h27;
		rstN = 1'b0;
		sampleValid = 1'b0;
		sampleKey = 5'h00;
		sampleSignal = 16'h0000;
		keyEnabled = 24'h0;
		keyCalibrating = 24'h0;
		keyCalFail = 24'h0;
		keyNormCount = 192'h0;
		setupWrEn = 1'b0;
		setupWrAddr = 7'h00;
		setupWrData = 8'h00;
		repeat (2) @(posedge refClk);
		rstN <= 1'b1;
		repeat (70) @(posedge refClk);
		for (int n = 0; n < 3; n++) begin
			lfsr = nextRand(lfsr);
			k = 5'(n * 6 + lfsr % 6);
			b = {8'h02, lfsr};
			sample(k, b);
			sample(k, b - 16'd9);
			check(keyDetect[k], 1'b0);
			sample(k, b - 16'd10);
			check(keyDetect[k], 1'b1);
			sample(k, b - 16'd9);
			check(keyDetect[k], 1'b1);
			sample(k, b - 16'd8);
			check(keyDetect[k], 1'b0);
			sample(k, b + 16'd6);
			check(keyPosOver[k], 1'b1);
			sample(k, b + 16'd5);
			check(keyPosOver[k], 1'b0);
		end
		lfsr = nextRand(lfsr);
		b = {8'h03, lfsr};
		keyNormCount[167:160] <= lfsr;
		sample(5'd20, b);
		query(8'h54, 5);
		check({got[1], got[0]}, b);
		check({got[3], got[2]}, b);
		check(got[4], lfsr);
		repeat (200) @(posedge refClk);
		sample(5'd20, b + 16'd2);
		sample(5'd20, b + 16'd2);
		refIs(5'd20, b + 16'd1);
		sample(5'd20, b - 16'd19);
		check(keyDetect[20], 1'b1);
		repeat (1100) @(posedge refClk);
		sample(5'd20, b - 16'd19);
		refIs(5'd20, b + 16'd1);
		sample(5'd20, b - 16'd2);
		sample(5'd20, b - 16'd2);
		repeat (900) @(posedge refClk);
		sample(5'd20, b - 16'd2);
		repeat (200) @(posedge refClk);
		sample(5'd20, b - 16'd2);
		refIs(5'd20, b - 16'd1);
		lfsr = nextRand(lfsr);
		keyEnabled[23:22] <= {1'b0, lfsr[0]};
		keyCalibrating[23:22] <= lfsr[2:1];
		keyCalFail[23:22] <= lfsr[4:3];
		sample(5'd22, 16'h0200);
		sample(5'd22, 16'h01e0);
		sample(5'd23, 16'h0050);
		for (int j = 22; j < 24; j++) begin
			st = {3'b000, keyEnabled[j], j == 22, j == 23, keyCalibrating[j], keyCalFail[j]};
			query({3'b100, 5'(j)}, 2);
			check(got[0], st);
			check(got[1], crcStep(crcStep(8'h00, {3'b100, 5'(j)}), st));
		end
		@(posedge refClk);
		setupWrEn <= 1'b1;
		setupWrAddr <= 7'h15;
		setupWrData <= 8'h01;
		@(posedge refClk);
		setupWrEn <= 1'b0;
		sample(5'd21, 16'h0300);
		sample(5'd21, 16'h02f7);
		check(keyDetect[21], 1'b0);
		xf(CMD_DUMP);
		check(scanHalt, 1'b1);
		s1 = crcStep(8'h00, CMD_DUMP);
		s2 = 8'h00;
		for (int a = 0; a < SETUP_BYTES; a++) begin
			xf(8'h00);
			st = a == 21 ? 8'h01 : setupExp(a);
			check(rx, st);
			s1 = crcStep(s1, st);
			s2 = crcStep(s2, st);
			if (a == 50) sample(5'd20, 16'h0000);
		end
		xf(8'h00);
		check(rx, s1);
		check(scanHalt, 1'b0);
		check(keyDetect[20], 1'b0);
		query(CMD_CRC, 1);
		check(got[0], s2);
		st = {4'h1, lfsr[3:0]};
		xf(st);
		check(commsErr, 1'b1);
		query(CMD_ECHO, 1);
		s1 = ~st;
		check(got[0], s1);
		check(commsErr, 1'b0);
		k = 5'd22;
		st = {3'b110, k};
		xf(st);
		xf(st);
		check(rx, 8'h00);
		xf(8'h00);
		s1 = ~st;
		check(rx, s1);
		sample(k, 16'h0123);
		repeat (3) @(posedge refClk);
		check(calCount, 1);
		check(lastCal, k);
		refIs(k, 16'h0123);
		xf(st);
		xf({4'h1, lfsr[7:4]});
		xf(st);
		xf(8'h00);
		check(rx, 8'h00);
		xf(st);
		repeat (WIN + 50) @(posedge refClk);
		xf(st);
		xf(8'h00);
		check(rx, 8'h00);
		sample(k, 16'h0123);
		repeat (3) @(posedge refClk);
		check(calCount, 1);
		rstN <= 1'b0;
		repeat (2) @(posedge refClk);
		rstN <= 1'b1;
		repeat (70) @(posedge refClk);
		sample(5'd21, 16'h0300);
		sample(5'd21, 16'h02f7);
		check(keyDetect[21], 1'b1);
		check(commsErr, 1'b0);
		results();
	end
endmodule
